//--- core/pll_regs_pkg.sv
// Package with register map, field positions and reset values for the PLL control registers
package pll_regs_pkg;
  localparam int unsigned REG_W = 8;
  localparam logic [1:0] IDX_MODE_STATUS = 2'h0;
  localparam logic [1:0] IDX_PHASE_CTRL = 2'h1;
  localparam logic [1:0] IDX_DAC_LOW = 2'h2;
  localparam logic [1:0] IDX_SHARED = 2'h3;
  // First control register fields
  localparam int unsigned MS_MODE_BIT = 7;
  localparam int unsigned MS_TRIG_OFF_BIT = 6;
  localparam int unsigned MS_SRC_LSB = 4;
  localparam int unsigned MS_RESTART_BIT = 3;
  localparam int unsigned MS_PFD_BIT = 2;
  localparam int unsigned MS_GAIN_BIT = 1;
  localparam int unsigned MS_LOCK_BIT = 0;
  // Second control register fields
  localparam int unsigned PC_FORCE_LOCK_BIT = 7;
  localparam int unsigned PC_GAIN_BIT = 6;
  localparam int unsigned PC_SHARED_SEL_BIT = 5;
  localparam int unsigned PC_HALF_BIT = 4;
  localparam int unsigned PC_PHASE_LSB = 0;
  localparam int unsigned PHASE_W = 4;
  // Reset values
  localparam logic [7:0] MODE_STATUS_RST = 8'h00;
  localparam logic [7:0] PHASE_CTRL_RST = 8'h00;
  localparam logic [7:0] DAC_BYTE_RST = 8'h00;
  localparam logic [3:0] TRIG_DELAY_RST = 4'h0;
  // Phase step in picoseconds and half period
  localparam int unsigned PHASE_STEP_PS = 1040;
  localparam int unsigned HALF_PERIOD_PS = 12475;
  localparam int unsigned PHASE_PS_W = 16;

  typedef enum logic [1:0] {
    SRC_TRIGGER,
    SRC_UP_N,
    SRC_DOWN_N,
    SRC_COMPARATOR
  } out_src_t;

  typedef struct packed {
    logic [1:0] index;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic cal_done;
    logic cal_high_gain;
    logic [15:0] cal_dac;
    logic upset_seen;
  } cal_status_t;
endpackage : pll_regs_pkg

//--- core/restart_detect.sv
// Detector for a one-then-zero write sequence on the restart bit
`timescale 1ns/100ps
`default_nettype none
module restart_detect (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic wr_strobe,
  input wire logic wr_bit,
  output logic restart_pulse
);
  logic armed_q;

  // Only the very next write after a one can fire the restart
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      armed_q <= 1'b0;
    end else if (wr_strobe) begin
      armed_q <= wr_bit;
    end
  end

  assign restart_pulse = wr_strobe && armed_q && !wr_bit;

  property p_no_restart_on_one;
    @(posedge clk_sys) disable iff (!resetn)
    (wr_strobe && wr_bit) |-> !restart_pulse;
  endproperty
  a_no_restart_on_one : assert property (p_no_restart_on_one)
    else $error("restart fired on a write of one");
endmodule // restart_detect
`default_nettype wire

//--- core/pll_mode_phase_control_regs.sv
// Mode, trigger routing, restart and phase control registers of the clock recovery PLL
// Contract
// - Any reset clears the mode bit, selecting normal auto-calibrated operation.
// - Mode bit one hands loop control and bias to the host registers.
// - Bit 6 at zero enables both trigger outputs, one disables; resets zero.
// - Bits 5:4 route trigger, inverted up, inverted down or comparator.
// - Writing one then zero to bit 3 restarts the loop.
// - Reading bit 3 returns the sticky upset flag.
// - Bit 2 forces the PFD only in test mode.
// - Bit 1 reads back the calibration loop-gain output normally, second-register bit 6 in test mode.
// - Bit 0 reads one after calibration and lock complete.
// - In test mode second-register bit 7 forces calibration complete.
// - In test mode second-register bit 6 sets loop gain directly.
// - Second-register bit 5 picks DAC high byte or delay at index 3.
// - Second-register bit 4 selects the upper half of the period.
// - Phase equals field times 1.04ns plus half period when selected.
// - Each access is one byte; two index bits select the register.
// - Software or hardware reset restarts calibration and restores defaults.
// - DAC reads give calibration value normally, host value in test mode.
`timescale 1ns/100ps
`default_nettype none
module pll_mode_phase_control_regs
  import pll_regs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire pll_regs_pkg::reg_req_t req,
  output logic [7:0] rdata_q,
  input wire pll_regs_pkg::cal_status_t cal,
  input wire logic trig_decoded,
  input wire logic pd_up,
  input wire logic pd_down,
  input wire logic loop_comparator,
  output logic trigger_out_a,
  output logic trigger_out_b,
  output logic test_mode,
  output logic force_pfd_use,
  output logic loop_gain_status,
  output logic cal_done_eff,
  output logic [15:0] vco_bias,
  output logic [3:0] trig_delay,
  output logic [3:0] phase_field,
  output logic phase_half_sel,
  output logic [15:0] phase_ps,
  output logic loop_restart
);
  import pll_regs_pkg::*;

  logic [7:0] mode_q;
  logic [7:0] phase_ctrl_q;
  logic [7:0] dac_low_q;
  logic [7:0] dac_high_q;
  logic [3:0] delay_q;
  logic soft_rst;
  logic wr_mode;
  logic trig_sel;
  logic trig_q;
  out_src_t src;

  assign wr_mode = req.wr && (req.index == IDX_MODE_STATUS);

  restart_detect u_restart (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .wr_strobe(wr_mode),
    .wr_bit(req.wdata[MS_RESTART_BIT]),
    .restart_pulse(soft_rst)
  );

  // Restart pulse goes to the calibration engine as well
  assign loop_restart = soft_rst;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mode_q <= MODE_STATUS_RST;
    end else if (soft_rst) begin
      mode_q <= MODE_STATUS_RST;
    end else if (wr_mode) begin
      mode_q <= req.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      phase_ctrl_q <= PHASE_CTRL_RST;
    end else if (soft_rst) begin
      phase_ctrl_q <= PHASE_CTRL_RST;
    end else if (req.wr && req.index == IDX_PHASE_CTRL) begin
      phase_ctrl_q <= req.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dac_low_q <= DAC_BYTE_RST;
      dac_high_q <= DAC_BYTE_RST;
      delay_q <= TRIG_DELAY_RST;
    end else if (soft_rst) begin
      dac_low_q <= DAC_BYTE_RST;
      dac_high_q <= DAC_BYTE_RST;
      delay_q <= TRIG_DELAY_RST;
    end else if (req.wr) begin
      if (req.index == IDX_DAC_LOW) begin
        dac_low_q <= req.wdata;
      end else if (req.index == IDX_SHARED) begin
        if (phase_ctrl_q[PC_SHARED_SEL_BIT]) begin
          delay_q <= req.wdata[3:0];
        end else begin
          dac_high_q <= req.wdata;
        end
      end
    end
  end

  assign test_mode = mode_q[MS_MODE_BIT];
  assign force_pfd_use = test_mode && mode_q[MS_PFD_BIT];
  assign loop_gain_status = test_mode ? phase_ctrl_q[PC_GAIN_BIT] : cal.cal_high_gain;
  assign cal_done_eff = cal.cal_done || (test_mode && phase_ctrl_q[PC_FORCE_LOCK_BIT]);
  assign vco_bias = test_mode ? {dac_high_q, dac_low_q} : cal.cal_dac;
  assign trig_delay = delay_q;
  assign phase_field = phase_ctrl_q[PC_PHASE_LSB +: PHASE_W];
  assign phase_half_sel = phase_ctrl_q[PC_HALF_BIT];
  // Host is expected to keep the field within 1..11; larger codes are passed unchanged
  assign phase_ps = 16'(32'(phase_field) * PHASE_STEP_PS
                        + (phase_half_sel ? HALF_PERIOD_PS : 0));

  assign src = out_src_t'(mode_q[MS_SRC_LSB +: 2]);
  always_comb begin
    case (src)
      SRC_TRIGGER: trig_sel = trig_decoded;
      SRC_UP_N: trig_sel = !pd_up;
      SRC_DOWN_N: trig_sel = !pd_down;
      SRC_COMPARATOR: trig_sel = loop_comparator;
      default: trig_sel = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= trig_sel && !mode_q[MS_TRIG_OFF_BIT];
    end
  end
  assign trigger_out_a = trig_q;
  assign trigger_out_b = trig_q;

  // Read data registered one cycle after the read strobe
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (req.rd) begin
      case (req.index)
        IDX_MODE_STATUS: rdata_q <= {mode_q[7:4], cal.upset_seen, mode_q[MS_PFD_BIT],
                                     loop_gain_status, cal_done_eff};
        IDX_PHASE_CTRL: rdata_q <= phase_ctrl_q;
        IDX_DAC_LOW: rdata_q <= test_mode ? dac_low_q : cal.cal_dac[7:0];
        IDX_SHARED: rdata_q <= phase_ctrl_q[PC_SHARED_SEL_BIT] ? {4'h0, delay_q}
                               : (test_mode ? dac_high_q : cal.cal_dac[15:8]);
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  property p_reset_mode;
    @(posedge clk_sys) disable iff (!resetn)
    soft_rst |=> !test_mode;
  endproperty
  a_reset_mode : assert property (p_reset_mode)
    else $error("mode not cleared by restart");

  // Restart must also drop the phase setting and the delay, not only the mode
  property p_reset_regs;
    @(posedge clk_sys) disable iff (!resetn)
    soft_rst |=> (phase_ctrl_q == PHASE_CTRL_RST) && (delay_q == TRIG_DELAY_RST);
  endproperty
  a_reset_regs : assert property (p_reset_regs)
    else $error("registers not cleared by restart");

  property p_trig_off;
    @(posedge clk_sys) disable iff (!resetn)
    $past(mode_q[MS_TRIG_OFF_BIT]) |-> !trigger_out_a && !trigger_out_b;
  endproperty
  a_trig_off : assert property (p_trig_off)
    else $error("trigger not disabled");

  property p_pfd;
    @(posedge clk_sys) disable iff (!resetn)
    !test_mode |-> !force_pfd_use;
  endproperty
  a_pfd : assert property (p_pfd)
    else $error("pfd forced outside test");

  property p_gain;
    @(posedge clk_sys) disable iff (!resetn)
    !test_mode |-> loop_gain_status == cal.cal_high_gain;
  endproperty
  a_gain : assert property (p_gain)
    else $error("gain not mirrored");

  property p_force_lock;
    @(posedge clk_sys) disable iff (!resetn)
    (test_mode && phase_ctrl_q[PC_FORCE_LOCK_BIT]) |-> cal_done_eff;
  endproperty
  a_force_lock : assert property (p_force_lock)
    else $error("lock not forced");

  property p_bias;
    @(posedge clk_sys) disable iff (!resetn)
    test_mode |-> vco_bias == {dac_high_q, dac_low_q};
  endproperty
  a_bias : assert property (p_bias)
    else $error("bias not from host");

  property p_upset;
    @(posedge clk_sys) disable iff (!resetn)
    (req.rd && req.index == IDX_MODE_STATUS)
      |=> rdata_q[MS_RESTART_BIT] == $past(cal.upset_seen);
  endproperty
  a_upset : assert property (p_upset)
    else $error("upset flag wrong");

  // Delay readback must not leak the unused upper nibble
  property p_shared_read;
    @(posedge clk_sys) disable iff (!resetn)
    (req.rd && req.index == IDX_SHARED && phase_ctrl_q[PC_SHARED_SEL_BIT])
      |=> rdata_q == {4'h0, $past(delay_q)};
  endproperty
  a_shared_read : assert property (p_shared_read)
    else $error("shared index read wrong");

  property p_phase;
    @(posedge clk_sys) disable iff (!resetn)
    phase_ps == 16'(32'(phase_field) * PHASE_STEP_PS
                    + (phase_half_sel ? HALF_PERIOD_PS : 0));
  endproperty
  a_phase : assert property (p_phase)
    else $error("phase wrong");
endmodule // pll_mode_phase_control_regs
`default_nettype wire

//--- dv/pll_host_model.sv
// Host model issuing one-byte register reads and writes
`timescale 1ns/100ps
`default_nettype none
module pll_host_model
  import pll_regs_pkg::*;
(
  input wire logic clk_sys,
  output var pll_regs_pkg::reg_req_t req,
  input wire logic [7:0] rdata_q,
  input wire logic loop_restart
);
  initial req = '0;
  // Held from one falling edge to the next so it spans the taking edge
  task automatic xfer(input logic [1:0] i, input logic [7:0] d, input logic w,
    output logic [7:0] q, output logic rs);
    @(negedge clk_sys);
    req <= '{index: i, wdata: d, wr: w, rd: !w};
    #1 rs = loop_restart;
    @(negedge clk_sys);
    req <= '0;
    q = rdata_q;
  endtask
endmodule // pll_host_model
`default_nettype wire

//--- dv/tb_pll_mode_phase_control_regs.sv
// Self-checking bench for the PLL mode, routing and phase registers
`timescale 1ns/100ps
`default_nettype none
module tb_pll_mode_phase_control_regs;
  import pll_regs_pkg::*;
  logic clk_sys, resetn, trig_decoded, pd_up, pd_down, loop_comparator, rs, arm;
  logic trigger_out_a, trigger_out_b, test_mode, force_pfd_use, loop_gain_status;
  logic cal_done_eff, phase_half_sel, loop_restart;
  logic [7:0] rdata_q, q;
  logic [15:0] vco_bias, phase_ps;
  logic [3:0] trig_delay, phase_field;
  logic [31:0] seed = 32'h9b9585de;
  reg_req_t req;
  cal_status_t cal;
  int miscompares = 0, compares = 0, m[5];
  pll_host_model pll_host_model_i(.clk_sys, .req, .rdata_q, .loop_restart);
  pll_mode_phase_control_regs pll_mode_phase_control_regs_i(.clk_sys, .resetn, .req,
    .rdata_q, .cal, .trig_decoded, .pd_up, .pd_down, .loop_comparator, .trigger_out_a,
    .trigger_out_b, .test_mode, .force_pfd_use, .loop_gain_status, .cal_done_eff,
    .vco_bias, .trig_delay, .phase_field, .phase_half_sel, .phase_ps, .loop_restart);
  initial begin
    clk_sys = 0;
    forever #25 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic stim();
    cal = 19'(rnd());
    {trig_decoded, pd_up, pd_down, loop_comparator} = 4'(rnd());
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  function automatic logic [7:0] exp_rd(input int i);
    logic t;
    t = m[0][7];
    case (i)
      0: return {m[0][7:4], cal.upset_seen, m[0][2], t ? m[1][6] : cal.cal_high_gain,
        cal.cal_done | t & m[1][7]};
      1: return m[1][7:0];
      2: return t ? m[2][7:0] : cal.cal_dac[7:0];
      default: return m[1][5] ? {4'h0, m[4][3:0]} : t ? m[3][7:0] : cal.cal_dac[15:8];
    endcase
  endfunction
  function automatic logic tx();
    logic [3:0] s;
    s = {loop_comparator, !pd_down, !pd_up, trig_decoded};
    return !m[0][6] && s[m[0][5:4]];
  endfunction
  task automatic pins();
    logic t;
    t = m[0][7];
    chk(test_mode, t);
    chk(force_pfd_use, t & m[0][2]);
    chk(loop_gain_status, t ? m[1][6] : cal.cal_high_gain);
    chk(cal_done_eff, cal.cal_done | t & m[1][7]);
    chk(vco_bias, t ? {m[3][7:0], m[2][7:0]} : cal.cal_dac);
    chk(trig_delay, m[4][3:0]);
    chk({phase_half_sel, phase_field}, m[1][4:0]);
    chk(phase_ps, 16'(m[1][3:0] * PHASE_STEP_PS + m[1][4] * HALF_PERIOD_PS));
  endtask
  task automatic wr(input logic [1:0] i, input logic [7:0] d);
    logic e;
    e = i == 0 && !d[3] && arm;
    pll_host_model_i.xfer(i, d, 1, q, rs);
    chk(rs, e);
    if (i == 0) arm = d[3];
    m[i == 3 && m[1][5] ? 4 : i] = d;
    if (e) m = '{default: 0};
    pins();
  endtask
  task automatic rdc(input logic [1:0] i);
    logic [7:0] e;
    e = exp_rd(i);
    pll_host_model_i.xfer(i, 8'h00, 0, q, rs);
    chk(q, e);
  endtask
  task automatic done(input string n);
    $display("test %0s done", n);
  endtask
  task automatic end_of_test();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #500000;
    miscompares++;
    end_of_test();
  end
  initial begin
    resetn = 0;
    arm = 0;
    m = '{default: 0};
    stim();
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    resetn = 1;
    for (int i = 0; i < 4; i++) rdc(i);
    done("reset");
    wr(2, 8'(rnd()) & 8'hf7);
    wr(3, 8'(rnd()) & 8'hf7);
    for (int i = 2; i < 4; i++) rdc(i);
    wr(0, 8'h84);
    for (int i = 2; i < 4; i++) rdc(i);
    done("dac");
    for (int k = 0; k < 8; k++) begin
      stim();
      wr(0, {k[2], 4'h0, k[1], 2'h0});
      wr(1, {k[1:0], 6'h0});
      rdc(0);
    end
    done("gain");
    for (int k = 0; k < 8; k++) begin
      wr(0, {1'b0, k[2:0], 4'h0});
      repeat (4) begin
        stim();
        @(negedge clk_sys);
        chk({trigger_out_a, trigger_out_b}, {2{tx()}});
      end
    end
    done("trigger");
    wr(1, 8'h20);
    wr(3, 8'(rnd()) & 8'hf7);
    rdc(3);
    wr(1, 8'h00);
    rdc(3);
    done("shared");
    // Codes 8..11 set bit 3 of index 1, which must not arm the restart
    for (int f = 1; f < 12; f++)
      for (int h = 0; h < 2; h++) wr(1, {3'(rnd()), h[0], f[3:0]});
    wr(0, 8'h00);
    done("phase");
    @(negedge clk_sys);
    resetn = 0;
    @(negedge clk_sys);
    resetn = 1;
    m = '{default: 0};
    arm = 0;
    pins();
    for (int i = 0; i < 4; i++) rdc(i);
    done("hard reset");
    wr(0, 8'h88);
    wr(0, 8'h80);
    for (int i = 0; i < 4; i++) rdc(i);
    done("restart");
    end_of_test();
  end
endmodule // tb_pll_mode_phase_control_regs
`default_nettype wire
